// file: sbtc_top.sv
// Sixteen-bit timer/counter with prescaler, buffered access and Avalon-MM registers
`timescale 1ns/100ps
`include "sbtc_defines.svh"
module sbtc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_count_input_i,
  input wire logic aux_osc_clk_i,
  input wire logic [1:0] port_c_pin_i,
  output logic [1:0] port_c_out_o,
  output logic [1:0] port_c_oe_o,
  input wire logic [1:0] special_event_i,
  input wire logic [3:0] compare_mode_select1_i,
  input wire logic [3:0] compare_mode_select2_i,
  output logic [4:0] ccp_uses_this_timer_o,
  output logic [15:0] count_o,
  output logic overflow_irq_o
);

  // ******************************************************************
  // Registers and state
  // ******************************************************************
  logic [7:0] ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0] hi_buf_r;
  logic overflow_flag_r;
  logic overflow_irq_enable_r;
  logic aux_osc_enable_r;
  logic [1:0] port_latch_r;
  logic [1:0] port_c_direction_r;
  logic [1:0] instr_div_r;
  logic [2:0] presc_r;
  logic ext_armed_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [1:0] port_pin_s1_r;
  logic [1:0] port_pin_s2_r;
  logic [1:0] port_pin_s3_r, port_pin_lvl_r;
  logic [4:0] units_r;
  logic irq_r;
  sbtc_pkg::sbtc_mode_t mode;

  // ******************************************************************
  // Bus decode
  // ******************************************************************
  logic req;
  logic rd_now;
  logic wr_now;
  logic wr_lane0;
  logic [7:0] wbyte;

  assign req = avs_read_i || avs_write_i;
  assign rd_now = avs_read_i && waitreq_r;
  assign wr_now = avs_write_i && !waitreq_r;
  assign wr_lane0 = wr_now && avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  function automatic logic wr_at(input logic [4:0] a, input logic [4:0] target, input logic en);
    wr_at = en && (a == target);
  endfunction
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_flag;
  logic wr_ien;
  logic wr_aux;
  logic wr_port;
  logic wr_dir;

  assign wr_ctrl = wr_at(avs_address_i, `SBTC_ADDR_CTRL, wr_lane0);
  assign wr_lo = wr_at(avs_address_i, `SBTC_ADDR_CNT_LO, wr_lane0);
  assign wr_hi = wr_at(avs_address_i, `SBTC_ADDR_CNT_HI, wr_lane0);
  assign wr_flag = wr_at(avs_address_i, `SBTC_ADDR_FLAG, wr_lane0);
  assign wr_ien = wr_at(avs_address_i, `SBTC_ADDR_IEN, wr_lane0);
  assign wr_aux = wr_at(avs_address_i, `SBTC_ADDR_AUX, wr_lane0);
  assign wr_port = wr_at(avs_address_i, `SBTC_ADDR_PORT, wr_lane0);
  assign wr_dir = wr_at(avs_address_i, `SBTC_ADDR_DIR, wr_lane0);

  logic wide;
  assign wide = ctrl_r[`SBTC_BIT_WIDE];

  // Wait one cycle then answer; keeps read data a registered value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waitreq_r <= 1'b1;
    end else if (req && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  // Read mux, sampled in the first request cycle and held for the answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_now) begin
      case (avs_address_i)
        `SBTC_ADDR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
        `SBTC_ADDR_CNT_LO: rdata_r <= {24'h00_0000, count_r[7:0]};
        `SBTC_ADDR_CNT_HI: rdata_r <= {24'h00_0000, wide ? hi_buf_r : count_r[15:8]};
        `SBTC_ADDR_FLAG: rdata_r <= {30'h0000_0000, overflow_flag_r, 1'b0};
        `SBTC_ADDR_IEN: rdata_r <= {30'h0000_0000, overflow_irq_enable_r, 1'b0};
        `SBTC_ADDR_AUX: rdata_r <= {28'h000_0000, aux_osc_enable_r, 3'h0};
        // Oscillator pins read as zero while the oscillator owns them
        `SBTC_ADDR_PORT: rdata_r <= {30'h0000_0000, aux_osc_enable_r ? 2'h0 : port_pin_lvl_r};
        `SBTC_ADDR_DIR: rdata_r <= {30'h0000_0000, port_c_direction_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ******************************************************************
  // Control and side registers
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SBTC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_irq_enable_r <= 1'b0;
      aux_osc_enable_r <= 1'b0;
      port_latch_r <= 2'h0;
      port_c_direction_r <= 2'h3;
    end else begin
      if (wr_ien) begin
        overflow_irq_enable_r <= wbyte[`SBTC_BIT_OVF];
      end
      if (wr_aux) begin
        aux_osc_enable_r <= wbyte[`SBTC_BIT_OSCEN];
      end
      if (wr_port) begin
        port_latch_r <= wbyte[1:0];
      end
      if (wr_dir) begin
        port_c_direction_r <= wbyte[1:0];
      end
    end
  end

  // Port pins pass three stages; a bit changes only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_pin_s1_r <= 2'h0;
      port_pin_s2_r <= 2'h0;
      port_pin_s3_r <= 2'h0;
      port_pin_lvl_r <= 2'h0;
    end else begin
      port_pin_s1_r <= port_c_pin_i;
      port_pin_s2_r <= port_pin_s1_r;
      port_pin_s3_r <= port_pin_s2_r;
      port_pin_lvl_r <= (port_pin_s2_r & port_pin_s3_r) | (port_pin_lvl_r & (port_pin_s2_r | port_pin_s3_r));
    end
  end

  // Pin drivers; the oscillator forces both pins to inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_c_out_o <= 2'h0;
      port_c_oe_o <= 2'h0;
    end else begin
      port_c_out_o <= port_latch_r;
      port_c_oe_o <= aux_osc_enable_r ? 2'h0 : ~port_c_direction_r;
    end
  end

  // ******************************************************************
  // Clock source, mode and prescaler
  // ******************************************************************
  logic ext_rise;
  logic ext_fall;

  sbtc_edge_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(aux_osc_enable_r ? aux_osc_clk_i : ext_count_input_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // Mode from source and bypass; bypass is meaningless on the internal clock
  always_comb begin
    if (!ctrl_r[`SBTC_BIT_SRC]) begin
      mode = sbtc_pkg::SBTC_MODE_TIMER;
    end else if (ctrl_r[`SBTC_BIT_BYPASS]) begin
      mode = sbtc_pkg::SBTC_MODE_ASYNC;
    end else begin
      mode = sbtc_pkg::SBTC_MODE_SYNC;
    end
  end

  // Instruction-cycle divider, free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_div_r <= 2'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  // Edge arming: a rising edge counts only after a falling one was seen
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_r[`SBTC_BIT_ON] || !ctrl_r[`SBTC_BIT_SRC]) begin
      ext_armed_r <= 1'b0;
    end else if (ext_fall) begin
      ext_armed_r <= 1'b1;
    end
  end

  logic raw_tick;
  always_comb begin
    case (mode)
      sbtc_pkg::SBTC_MODE_TIMER: raw_tick = (instr_div_r == `SBTC_INSTR_LAST);
      sbtc_pkg::SBTC_MODE_SYNC,
      sbtc_pkg::SBTC_MODE_ASYNC: raw_tick = ext_rise && ext_armed_r;
      default: raw_tick = 1'b0;
    endcase
  end

  // Prescale terminal count: 1:1, 1:2, 1:4, 1:8
  logic [2:0] presc_last;
  always_comb begin
    case (ctrl_r[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO])
      2'h0: presc_last = 3'h0;
      2'h1: presc_last = 3'h1;
      2'h2: presc_last = 3'h3;
      default: presc_last = 3'h7;
    endcase
  end

  logic on;
  logic count_tick;
  assign on = ctrl_r[`SBTC_BIT_ON];
  assign count_tick = on && raw_tick && (presc_r == presc_last);

  // Prescaler; cleared by low-byte writes only, so high-byte writes keep phase
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_lo) begin
      presc_r <= 3'h0;
    end else if (on && raw_tick) begin
      presc_r <= (presc_r == presc_last) ? 3'h0 : presc_r + `SBTC_PS_ONE;
    end
  end

  // ******************************************************************
  // Counter, buffer and special event
  // ******************************************************************
  logic [4:0] units;
  always_comb begin
    case ({ctrl_r[`SBTC_BIT_TB_HI], ctrl_r[`SBTC_BIT_TB_LO]})
      `SBTC_TB_ALL: units = `SBTC_UNITS_ALL;
      `SBTC_TB_SPLIT2: units = `SBTC_UNITS_SPLIT2;
      `SBTC_TB_SPLIT1: units = `SBTC_UNITS_SPLIT1;
      default: units = `SBTC_UNITS_NONE;
    endcase
  end

  // Async mode may miss the reset; this design simply ignores it there
  logic spec_reset;
  assign spec_reset = (mode != sbtc_pkg::SBTC_MODE_ASYNC) && (
                      (special_event_i[0] && units[0] && compare_mode_select1_i == `SBTC_CMP_SPECIAL) ||
                      (special_event_i[1] && units[1] && compare_mode_select2_i == `SBTC_CMP_SPECIAL));

  logic overflow;
  assign overflow = count_tick && (count_r == `SBTC_CNT_MAX) && !wr_lo && !(wr_hi && !wide) && !spec_reset;

  // Priority: software write, then special reset, then count
  always_comb begin
    count_nxt = count_r;
    if (wr_lo) begin
      count_nxt = wide ? {hi_buf_r, wbyte} : {count_r[15:8], wbyte};
    end else if (wr_hi && !wide) begin
      count_nxt = {wbyte, count_r[7:0]};
    end else if (spec_reset) begin
      count_nxt = `SBTC_CNT_ZERO;
    end else if (count_tick) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= `SBTC_CNT_ZERO;
    end else begin
      count_r <= count_nxt;
    end
  end

  // High-byte buffer: low read latches live high, high write loads it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_buf_r <= 8'h00;
    end else if (wide && wr_hi) begin
      hi_buf_r <= wbyte;
    end else if (wide && rd_now && avs_address_i == `SBTC_ADDR_CNT_LO) begin
      hi_buf_r <= count_r[15:8];
    end
  end

  // Sticky flag; an overflow in the clearing cycle still wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_r <= 1'b0;
    end else if (overflow) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_flag) begin
      overflow_flag_r <= wbyte[`SBTC_BIT_OVF];
    end
  end

  // ******************************************************************
  // Registered outputs
  // ******************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
      units_r <= `SBTC_UNITS_NONE;
    end else begin
      irq_r <= overflow_flag_r && overflow_irq_enable_r;
      units_r <= units;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = waitreq_r;
  assign count_o = count_r;
  assign overflow_irq_o = irq_r;
  assign ccp_uses_this_timer_o = units_r;

endmodule

// file: sbtc_defines.svh
// Constants for the sixteen-bit timer/counter: offsets, fields, reset values
// Overview of operation
// - Top control bit selects buffered 16-bit access
// - Two-bit field maps compare units to timers
// - Prescale field divides input by 1/2/4/8
// - Bypass bit selects async mode; input still passes synchroniser
// - Internal source ignores the bypass bit
// - Internal source counts instruction cycles, clock/4
// - External rising edges count after first fall
// - Three modes: timer, sync, async counter
// - Oscillator enable forces pins input, reads zero
// - Low byte read latches high byte buffer
// - Low byte write loads buffered high byte
// - Wide mode: high byte only via buffer
// - Low byte write clears prescaler, high not
// - Count wraps FFFF to 0000, overflow event
// - Overflow sets sticky flag until software clears
// - Enable bit gates the overflow request
// - Compare special event resets count, not async
// - Software write beats simultaneous special reset
// - Special event reset never sets overflow flag
`ifndef SBTC_DEFINES_SVH
`define SBTC_DEFINES_SVH

// Register byte addresses on the Avalon-MM word bus
`define SBTC_ADDR_CTRL 5'h00
`define SBTC_ADDR_CNT_LO 5'h04
`define SBTC_ADDR_CNT_HI 5'h08
`define SBTC_ADDR_FLAG 5'h0c
`define SBTC_ADDR_IEN 5'h10
`define SBTC_ADDR_AUX 5'h14
`define SBTC_ADDR_PORT 5'h18
`define SBTC_ADDR_DIR 5'h1c

// Control register fields
`define SBTC_CTRL_RESET 8'h00
`define SBTC_BIT_WIDE 7
`define SBTC_BIT_TB_HI 6
`define SBTC_BIT_PS_HI 5
`define SBTC_BIT_PS_LO 4
`define SBTC_BIT_TB_LO 3
`define SBTC_BIT_BYPASS 2
`define SBTC_BIT_SRC 1
`define SBTC_BIT_ON 0

// Flag, enable and oscillator bits
`define SBTC_BIT_OVF 1
`define SBTC_BIT_OSCEN 3

// Compare mode that fires the special event
`define SBTC_CMP_SPECIAL 4'hb

// Time-base select encodings
`define SBTC_TB_NONE 2'h0
`define SBTC_TB_SPLIT1 2'h1
`define SBTC_TB_SPLIT2 2'h2
`define SBTC_TB_ALL 2'h3

// Unit masks (bit 0 = first enhanced unit .. bit 4 = last standard unit)
`define SBTC_UNITS_NONE 5'h00
`define SBTC_UNITS_SPLIT1 5'h1e
`define SBTC_UNITS_SPLIT2 5'h1c
`define SBTC_UNITS_ALL 5'h1f

// Misc widths and counts
`define SBTC_CNT_MAX 16'hffff
`define SBTC_CNT_ZERO 16'h0000
`define SBTC_INSTR_LAST 2'h3
`define SBTC_PS_ONE 3'h1

`endif

// file: sbtc_pkg.sv
// Types shared by the sixteen-bit timer/counter
package sbtc_pkg;

  // Operating mode chosen by source select and bypass bit
  typedef enum logic [1:0] {
    SBTC_MODE_TIMER,
    SBTC_MODE_SYNC,
    SBTC_MODE_ASYNC
  } sbtc_mode_t;

endpackage

// file: sbtc_edge_sync.sv
// Three-stage pin synchroniser with edge detection for the external count clock
`timescale 1ns/100ps
module sbtc_edge_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  // Chain; the first stage feeds only the second to avoid metastable fan-out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_r <= s3_r;
    end
  end

  assign rise_o = (s2_r == s3_r) && s3_r && !level_r;
  assign fall_o = (s2_r == s3_r) && !s3_r && level_r;

endmodule

// file: sbtc_top_props.sv
// Concurrent port checks for the sixteen-bit timer/counter
`timescale 1ns/100ps
module sbtc_top_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] port_c_oe_o,
  input wire logic [1:0] special_event_i,
  input wire logic [3:0] compare_mode_select1_i,
  input wire logic [4:0] ccp_uses_this_timer_o,
  input wire logic [15:0] count_o,
  input wire logic overflow_irq_o
);
  // ****
  // Helpers and properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ok;
  logic [7:0] wd_q;
  // A write counts only at its answer edge with the low lane enabled
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  // Held copy of write data, since the master may change it after the answer
  always_ff @(posedge clk_i) begin
    wd_q <= avs_writedata_i[7:0];
  end
  // Async counter mode may ignore the special reset, so that check skips it
  logic async_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      async_q <= 1'b0;
    end else if (wr_ok && avs_address_i == 5'h00) begin
      async_q <= avs_writedata_i[2] && avs_writedata_i[1];
    end
  end
  function automatic logic [4:0] units(input logic [31:0] d);
    case ({d[6], d[3]})
      2'h3: units = 5'h1f;
      2'h1: units = 5'h1e;
      2'h2: units = 5'h1c;
      default: units = 5'h00;
    endcase
  endfunction
  AST_RESET_STATE: assert property ($fell(rst_i) |-> count_o == 16'h0 && avs_waitrequest_o
    && !overflow_irq_o && ccp_uses_this_timer_o == 5'h0 && port_c_oe_o == 2'h0)
    else $error("state after reset not cleared");
  AST_COUNT_STEP: assert property (!$past(avs_write_i) && $past(special_event_i) == 2'h0
    |-> count_o == $past(count_o) || count_o == $past(count_o) + 16'h1)
    else $error("count moved by more than one");
  AST_IRQ_CAUSE: assert property ($rose(overflow_irq_o) |-> $past(avs_write_i, 2)
    || ($past(count_o, 2) == 16'hffff && $past(count_o) == 16'h0))
    else $error("request raised without wrap or write");
  AST_IRQ_STICKY: assert property ($fell(overflow_irq_o) |-> $past(avs_write_i, 2))
    else $error("request dropped without a write");
  AST_SPECIAL: assert property (special_event_i[0] && ccp_uses_this_timer_o[0]
    && compare_mode_select1_i == 4'hb && !avs_write_i && !async_q |=> count_o == 16'h0)
    else $error("special event did not clear count");
  AST_LOW_WRITE: assert property (wr_ok && avs_address_i == 5'h04 |=> count_o[7:0] == wd_q)
    else $error("low byte write lost");
  AST_UNITS: assert property (wr_ok && avs_address_i == 5'h00
    |-> ##2 ccp_uses_this_timer_o == units({24'h00_0000, wd_q}))
    else $error("unit mask wrong");
  AST_OSC_PINS: assert property (wr_ok && avs_address_i == 5'h14 && avs_writedata_i[3]
    |-> ##2 port_c_oe_o == 2'h0)
    else $error("pins driven with oscillator on");
  COV_WRAP: cover property (count_o == 16'hffff ##1 count_o == 16'h0);
  COV_SPECIAL: cover property (special_event_i[0] && ccp_uses_this_timer_o[0]);
  COV_IRQ: cover property ($rose(overflow_irq_o));
endmodule
bind sbtc_top sbtc_top_props chk_u (.*);

// file: sbtc_far_model.sv
// Far-side model: count pin, oscillator waveform and compare units
`timescale 1ns/100ps
module sbtc_far_model (
  input wire logic clk_i,
  output logic ext_o,
  output logic aux_o,
  output logic [1:0] evt_o,
  output logic [3:0] mode1_o,
  output logic [3:0] mode2_o
);
  // ****
  // Stimulus sources
  // ****
  // Lines rest at a level between bursts; the oscillator idles high
  initial begin
    ext_o = 1'b0;
    aux_o = 1'b1;
    evt_o = 2'h0;
    mode1_o = 4'h0;
    mode2_o = 4'h0;
  end
  // Eight clocks per half, slow enough for the synchroniser; never the system clock
  task automatic pulses(input logic osc, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (8) @(posedge clk_i);
      if (osc) aux_o <= ~aux_o;
      else ext_o <= ~ext_o;
    end
  endtask
  task automatic set_mode(input logic [3:0] m1, input logic [3:0] m2);
    mode1_o <= m1;
    mode2_o <= m2;
  endtask
  // One-cycle compare event after d edges
  task automatic fire(input logic [1:0] u, input int d);
    repeat (d) @(posedge clk_i);
    evt_o <= u;
    @(posedge clk_i);
    evt_o <= 2'h0;
  endtask
endmodule

// file: tb_sixteen_bit_timer_counter.sv
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/100ps
module tb_sixteen_bit_timer_counter;
  // ****
  // Signals, instances and shared tasks
  // ****
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic ext_count_input_i;
  logic aux_osc_clk_i;
  logic [1:0] port_c_pin_i = 2'h2;
  logic [1:0] port_c_out_o;
  logic [1:0] port_c_oe_o;
  logic [1:0] special_event_i;
  logic [3:0] compare_mode_select1_i;
  logic [3:0] compare_mode_select2_i;
  logic [4:0] ccp_uses_this_timer_o;
  logic [15:0] count_o;
  logic overflow_irq_o;
  logic [7:0] q;
  logic [15:0] s;
  logic [4:0] tbl [4] = '{5'h00, 5'h1e, 5'h1c, 5'h1f};
  int n_mismatch = 0;
  int comparisons = 0;
  sbtc_top dut_u (.*);
  sbtc_far_model far_u (.clk_i(clk_i), .ext_o(ext_count_input_i), .aux_o(aux_osc_clk_i),
    .evt_o(special_event_i), .mode1_o(compare_mode_select1_i), .mode2_o(compare_mode_select2_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; released one edge apart from the next
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (k == 40) begin
      n_mismatch++;
      $display("Error at %0t: bus timeout", $time);
      complete_run();
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    bus(0, 5'h00, 8'h0);
    chk(q, 8'h00);
    bus(0, 5'h1c, 8'h0);
    chk(q, 8'h03);
    bus(1, 5'h1c, 8'h00);
    bus(1, 5'h18, 8'h01);
    repeat (2) @(posedge clk_i);
    chk(port_c_oe_o, 2'h3);
    chk(port_c_out_o, 2'h1);
  endtask
  // Each rate is measured over a whole number of periods; rate 1:8 also sets bypass
  task automatic t_prescale();
    for (int p = 0; p < 4; p++) begin
      bus(1, 5'h00, {2'h0, 2'(p), 1'b0, p == 3, 2'h1});
      repeat (40) @(posedge clk_i);
      s = count_o;
      repeat (24 << p) @(posedge clk_i);
      chk(count_o - s, 16'h6);
    end
    bus(1, 5'h00, 8'h00);
    s = count_o;
    repeat (40) @(posedge clk_i);
    chk(count_o, s);
  endtask
  task automatic t_lowclr();
    bus(1, 5'h00, 8'h31);
    bus(1, 5'h04, 8'h00);
    repeat (26) @(posedge clk_i);
    chk(count_o[7:0], 8'h00);
    repeat (8) @(posedge clk_i);
    chk(count_o[7:0], 8'h01);
    bus(1, 5'h00, 8'h00);
    bus(1, 5'h08, 8'h77);
    @(posedge clk_i);
    chk(count_o[15:8], 8'h77);
  endtask
  task automatic t_wide();
    bus(1, 5'h00, 8'h80);
    bus(1, 5'h08, 8'hab);
    bus(1, 5'h04, 8'hcd);
    @(posedge clk_i);
    chk(count_o, 16'habcd);
    bus(1, 5'h08, 8'h55);
    @(posedge clk_i);
    chk(count_o, 16'habcd);
    bus(0, 5'h04, 8'h0);
    bus(0, 5'h08, 8'h0);
    chk(q, 8'hab);
    bus(1, 5'h00, 8'h81);
    bus(1, 5'h08, 8'h12);
    bus(1, 5'h04, 8'hf0);
    bus(0, 5'h04, 8'h0);
    repeat (200) @(posedge clk_i);
    bus(0, 5'h08, 8'h0);
    chk(q, 8'h12);
  endtask
  task automatic t_overflow();
    int k;
    k = 0;
    bus(1, 5'h00, 8'h00);
    bus(1, 5'h08, 8'hff);
    bus(1, 5'h04, 8'hfd);
    bus(1, 5'h00, 8'h01);
    while (count_o !== 16'h0 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    chk(k < 40, 1'b1);
    repeat (2) @(posedge clk_i);
    bus(0, 5'h0c, 8'h0);
    chk(q[1], 1'b1);
    chk(overflow_irq_o, 1'b0);
    bus(1, 5'h10, 8'h02);
    repeat (2) @(posedge clk_i);
    chk(overflow_irq_o, 1'b1);
    bus(1, 5'h0c, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(overflow_irq_o, 1'b0);
  endtask
  // The pin idles low, so the first rise is not counted
  task automatic t_ext();
    bus(1, 5'h00, 8'h00);
    bus(1, 5'h08, 8'h00);
    bus(1, 5'h04, 8'h00);
    bus(1, 5'h00, 8'h03);
    far_u.pulses(0, 10);
    repeat (8) @(posedge clk_i);
    chk(count_o, 16'h4);
    far_u.pulses(0, 1);
    bus(1, 5'h00, 8'h07);
    far_u.pulses(0, 6);
    repeat (8) @(posedge clk_i);
    chk(count_o, 16'h8);
    bus(0, 5'h18, 8'h0);
    chk(q[1:0], 2'h2);
    bus(1, 5'h14, 8'h08);
    repeat (3) @(posedge clk_i);
    chk(port_c_oe_o, 2'h0);
    bus(0, 5'h18, 8'h0);
    chk(q[1:0], 2'h0);
    far_u.pulses(1, 6);
    repeat (8) @(posedge clk_i);
    chk(count_o, 16'hb);
  endtask
  task automatic t_special();
    for (int i = 0; i < 4; i++) begin
      bus(1, 5'h00, {1'b0, 1'(i >> 1), 2'h0, 1'(i), 3'h0});
      repeat (2) @(posedge clk_i);
      chk(ccp_uses_this_timer_o, tbl[i]);
    end
    bus(1, 5'h00, 8'h48);
    far_u.set_mode(4'hb, 4'h0);
    far_u.fire(2'h1, 1);
    repeat (2) @(posedge clk_i);
    chk(count_o, 16'h0);
    bus(0, 5'h0c, 8'h0);
    chk(q[1], 1'b0);
    bus(1, 5'h04, 8'h55);
    far_u.fire(2'h2, 1);
    repeat (2) @(posedge clk_i);
    chk(count_o, 16'h0055);
    fork
      bus(1, 5'h04, 8'h99);
      far_u.fire(2'h1, 2);
    join
    repeat (2) @(posedge clk_i);
    chk(count_o, 16'h0099);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prescale();
    t_lowclr();
    t_wide();
    t_overflow();
    t_ext();
    t_special();
    complete_run();
  end
endmodule
